/* cbs_exec_top.v */
// Branch, I/O bit and shift execution unit with an APB register slave
//
// Overview of operation
// (RQ1) Branch on overflow clear: program counter plus offset plus one; 1 or 2 cycles.
// (RQ2) Branch if interrupts enabled: taken when I is one; 1 or 2 cycles.
// (RQ3) Branch if interrupts disabled: taken when I is zero; 1 or 2 cycles.
// (RQ4) These branches leave every status flag unchanged.
// (RQ5) I/O bit set forces the chosen bit to one; flags kept; two cycles.
// (RQ6) I/O bit clear forces the chosen bit to zero; flags kept; two cycles.
// (RQ7) Logical left shift, zero into bit 0; Z C N V updated; one cycle.
// (RQ8) Logical right shift, zero into bit 7; Z C N V updated; one cycle.
// (RQ9) Rotate left through carry; old bit 7 to carry; Z C N V; one cycle.
// (RQ10) Rotate right through carry; old bit 0 to carry; Z C N V; one cycle.
// (RQ11) Arithmetic right shift moves bits 1..7 down; Z C N V; one cycle.
// (RQ12) Nibble swap exchanges halves in one cycle; flags unchanged.
// (RQ13) Arithmetic right shift keeps bit 7; bit 0 goes to carry.
// (RQ14) Branch offset is signed word count added to incremented counter.
`timescale 1ns/100ps
`include "cbs_exec_regs.vh"

module cbs_exec_top
#(
  parameter PC_W   = 16,
  parameter K_W    = 7,
  parameter NREG   = 32,
  parameter NIO    = 32
)
(
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg         exec_busy
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam ST_IDLE = 3'b001;
  localparam ST_EX1  = 3'b010;
  localparam ST_EX2  = 3'b100;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  reg  [7:0]      rf [0:NREG-1];
  reg  [7:0]      io [0:NIO-1];
  reg  [2:0]      state;
  reg  [2:0]      next_state;
  reg  [3:0]      op;
  reg  [4:0]      idx;
  reg  [2:0]      bit_sel;
  reg  [K_W-1:0]  k;
  reg  [PC_W-1:0] program_counter;
  reg  [7:0]      sreg;
  reg  [5:0]      sel;
  reg  [7:0]      io_tmp;
  reg             last_taken;
  reg             illegal;
  reg  [1:0]      cycles;
  integer         i;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire        setup;
  wire        wr_en;
  wire        hit;
  wire        idle;
  reg  [31:0] rd_mux;

  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pready & pwrite & ~pslverr;
  assign idle  = state[0];
  assign hit   = (paddr == `CBS_OFS_CTRL) | (paddr == `CBS_OFS_OPERAND) |
                 (paddr == `CBS_OFS_PC) | (paddr == `CBS_OFS_SREG) |
                 (paddr == `CBS_OFS_SEL) | (paddr == `CBS_OFS_DATA) |
                 (paddr == `CBS_OFS_STATUS);

  wire [7:0] sel_data;
  assign sel_data = sel[`CBS_SEL_IO] ? io[sel[4:0]] : rf[sel[4:0]];

  always @*
  begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      `CBS_OFS_CTRL:
        rd_mux[`CBS_CTRL_OP_MSB:0] = op;
      `CBS_OFS_OPERAND:
      begin
        rd_mux[`CBS_OPND_IDX_MSB:0]                 = idx;
        rd_mux[`CBS_OPND_BIT_MSB:`CBS_OPND_BIT_LSB] = bit_sel;
        rd_mux[`CBS_OPND_K_LSB+K_W-1:`CBS_OPND_K_LSB] = k;
      end
      `CBS_OFS_PC:
        rd_mux[PC_W-1:0] = program_counter;
      `CBS_OFS_SREG:
        rd_mux[7:0] = sreg;
      `CBS_OFS_SEL:
        rd_mux[5:0] = sel;
      `CBS_OFS_DATA:
        rd_mux[7:0] = sel_data;
      `CBS_OFS_STATUS:
      begin
        rd_mux[`CBS_STAT_BUSY]    = ~idle;
        rd_mux[`CBS_STAT_TAKEN]   = last_taken;
        rd_mux[`CBS_STAT_ILLEGAL] = illegal;
        rd_mux[`CBS_STAT_CYC_MSB:`CBS_STAT_CYC_LSB] = cycles;
      end
      default:
        rd_mux = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // APB answer: one cycle access phase, all outputs registered
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= setup;
      pslverr <= setup & ~hit;
      if (setup && !pwrite && hit)
        prdata <= rd_mux;
      else if (setup)
        prdata <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Datapath units
  // ----------------------------------------------------------------
  wire [7:0]      sh_dout;
  wire            sh_c;
  wire            sh_z;
  wire            sh_n;
  wire            sh_v;
  wire            sh_upd;
  wire            br_taken;
  wire            br_is;
  wire [PC_W-1:0] br_next;

  cbs_shift_unit u_shift
  (
    .op        (op),
    .din       (rf[idx]),
    .cin       (sreg[`CBS_F_C]),
    .dout      (sh_dout),
    .c_out     (sh_c),
    .z_out     (sh_z),
    .n_out     (sh_n),
    .v_out     (sh_v),
    .flags_upd (sh_upd)
  );

  cbs_branch_unit #(
    .PC_W (PC_W),
    .K_W  (K_W)
  ) u_branch
  (
    .op        (op),
    .pc        (program_counter),
    .k         (k),
    .sreg      (sreg),
    .taken     (br_taken),
    .is_branch (br_is),
    .next_pc   (br_next)
  );

  wire is_io;
  wire is_shift;
  wire start;

  assign is_io    = (op == `CBS_OP_IO_SET) | (op == `CBS_OP_IO_CLR);
  assign is_shift = (op == `CBS_OP_SH_LEFT) | (op == `CBS_OP_SH_RIGHT) |
                    (op == `CBS_OP_RT_LEFT) | (op == `CBS_OP_RT_RIGHT) |
                    (op == `CBS_OP_SH_ARITH) | (op == `CBS_OP_SWAP);
  assign start    = wr_en & (paddr == `CBS_OFS_CTRL) & pwdata[`CBS_CTRL_START] & idle;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always @*
  begin
    case (state)
      ST_IDLE:
        next_state = start ? ST_EX1 : ST_IDLE;
      ST_EX1:
      begin
        if ((br_is && br_taken) || is_io)
          next_state = ST_EX2; // RQ1 RQ2 RQ3 RQ5 RQ6
        else
          next_state = ST_IDLE;
      end
      ST_EX2:
        next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state     <= ST_IDLE;
      exec_busy <= 1'b0;
    end
    else
    begin
      state     <= next_state;
      exec_busy <= ~next_state[0];
    end
  end

  // ----------------------------------------------------------------
  // Architectural state: counter, flags, register file, I/O space
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      op              <= 4'h0;
      idx             <= 5'h00;
      bit_sel         <= 3'h0;
      k               <= {K_W{1'b0}};
      program_counter <= {PC_W{1'b0}};
      sreg            <= `CBS_RST_SREG;
      sel             <= 6'h00;
      io_tmp          <= 8'h00;
      last_taken      <= 1'b0;
      illegal         <= 1'b0;
      cycles          <= 2'h0;
      for (i = 0; i < NREG; i = i + 1)
        rf[i] <= 8'h00;
      for (i = 0; i < NIO; i = i + 1)
        io[i] <= 8'h00;
    end
    else
    begin
      // Software writes; all registers but sel are frozen while busy
      if (wr_en && idle)
      begin
        case (paddr)
          `CBS_OFS_CTRL:
            op <= pwdata[`CBS_CTRL_OP_MSB:0];
          `CBS_OFS_OPERAND:
          begin
            idx     <= pwdata[`CBS_OPND_IDX_MSB:0];
            bit_sel <= pwdata[`CBS_OPND_BIT_MSB:`CBS_OPND_BIT_LSB];
            k       <= pwdata[`CBS_OPND_K_LSB+K_W-1:`CBS_OPND_K_LSB];
          end
          `CBS_OFS_PC:
            program_counter <= pwdata[PC_W-1:0];
          `CBS_OFS_SREG:
            sreg <= pwdata[7:0];
          `CBS_OFS_DATA:
          begin
            if (sel[`CBS_SEL_IO])
              io[sel[4:0]] <= pwdata[7:0];
            else
              rf[sel[4:0]] <= pwdata[7:0];
          end
          default:
            sel <= sel;
        endcase
      end
      if (wr_en && paddr == `CBS_OFS_SEL)
        sel <= pwdata[5:0];

      case (state)
        ST_IDLE:
        begin
          if (start)
          begin
            last_taken <= 1'b0;
            illegal    <= 1'b0;
          end
        end
        ST_EX1:
        begin
          if (br_is)
          begin
            program_counter <= br_next; // RQ1 RQ2 RQ3 RQ14
            last_taken      <= br_taken;
            cycles          <= br_taken ? `CBS_CYC_TWO : `CBS_CYC_ONE; // RQ1 RQ2 RQ3
            // Flags untouched on branches
            sreg            <= sreg; // RQ4
          end
          else if (is_io)
          begin
            io_tmp          <= io[idx];
            program_counter <= program_counter + {{(PC_W-1){1'b0}}, 1'b1};
            cycles          <= `CBS_CYC_TWO; // RQ5 RQ6
          end
          else if (is_shift)
          begin
            rf[idx]         <= sh_dout; // RQ7 RQ8 RQ9 RQ10 RQ11 RQ12
            program_counter <= program_counter + {{(PC_W-1){1'b0}}, 1'b1};
            cycles          <= `CBS_CYC_ONE; // RQ7 RQ8 RQ9 RQ10 RQ11 RQ12
            if (sh_upd)
            begin
              sreg[`CBS_F_C] <= sh_c; // RQ7 RQ8 RQ9 RQ10 RQ11 RQ13
              sreg[`CBS_F_Z] <= sh_z;
              sreg[`CBS_F_N] <= sh_n;
              sreg[`CBS_F_V] <= sh_v;
            end
          end
          else
          begin
            illegal <= 1'b1;
            cycles  <= `CBS_CYC_ONE;
          end
        end
        ST_EX2:
        begin
          // Second cycle of an I/O bit access writes back one bit only
          if (is_io)
          begin
            if (op == `CBS_OP_IO_SET)
              io[idx] <= io_tmp | (8'h01 << bit_sel); // RQ5
            else
              io[idx] <= io_tmp & ~(8'h01 << bit_sel); // RQ6
          end
        end
        default:
          cycles <= cycles;
      endcase
    end
  end

endmodule // cbs_exec_top

/* cbs_exec_regs.vh */
// Register offsets, field positions, opcodes and cycle counts of the execution block
`ifndef CBS_EXEC_REGS_VH
`define CBS_EXEC_REGS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define CBS_OFS_CTRL      8'h00
`define CBS_OFS_OPERAND   8'h04
`define CBS_OFS_PC        8'h08
`define CBS_OFS_SREG      8'h0C
`define CBS_OFS_SEL       8'h10
`define CBS_OFS_DATA      8'h14
`define CBS_OFS_STATUS    8'h18

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CBS_CTRL_OP_MSB   3
`define CBS_CTRL_START    4
`define CBS_OPND_IDX_MSB  4
`define CBS_OPND_BIT_LSB  8
`define CBS_OPND_BIT_MSB  10
`define CBS_OPND_K_LSB    16
`define CBS_SEL_IO        5
`define CBS_STAT_BUSY     0
`define CBS_STAT_TAKEN    1
`define CBS_STAT_ILLEGAL  2
`define CBS_STAT_CYC_LSB  4
`define CBS_STAT_CYC_MSB  5

// Status flag positions
`define CBS_F_C           0
`define CBS_F_Z           1
`define CBS_F_N           2
`define CBS_F_V           3
`define CBS_F_S           4
`define CBS_F_H           5
`define CBS_F_T           6
`define CBS_F_I           7

// ----------------------------------------------------------------
// Operation codes
// ----------------------------------------------------------------
`define CBS_OP_BR_OVF_CLR 4'h0
`define CBS_OP_BR_INT_EN  4'h1
`define CBS_OP_BR_INT_DIS 4'h2
`define CBS_OP_IO_SET     4'h3
`define CBS_OP_IO_CLR     4'h4
`define CBS_OP_SH_LEFT    4'h5
`define CBS_OP_SH_RIGHT   4'h6
`define CBS_OP_RT_LEFT    4'h7
`define CBS_OP_RT_RIGHT   4'h8
`define CBS_OP_SH_ARITH   4'h9
`define CBS_OP_SWAP       4'hA

// ----------------------------------------------------------------
// Reset values and cycle counts
// ----------------------------------------------------------------
`define CBS_RST_SREG      8'h00
`define CBS_CYC_ONE       2'h1
`define CBS_CYC_TWO       2'h2

`endif

/* cbs_shift_unit.v */
// Shift, rotate and nibble-swap datapath with status flag results
`timescale 1ns/100ps
`include "cbs_exec_regs.vh"

module cbs_shift_unit
(
  input  wire [3:0] op,
  input  wire [7:0] din,
  input  wire       cin,
  output reg  [7:0] dout,
  output reg        c_out,
  output wire       z_out,
  output wire       n_out,
  output wire       v_out,
  output reg        flags_upd
);

  // ----------------------------------------------------------------
  // Result and carry
  // ----------------------------------------------------------------
  always @*
  begin
    dout      = din;
    c_out     = cin;
    flags_upd = 1'b1;
    case (op)
      `CBS_OP_SH_LEFT:
      begin
        dout  = {din[6:0], 1'b0}; // RQ7
        c_out = din[7];
      end
      `CBS_OP_SH_RIGHT:
      begin
        dout  = {1'b0, din[7:1]}; // RQ8
        c_out = din[0];
      end
      `CBS_OP_RT_LEFT:
      begin
        dout  = {din[6:0], cin}; // RQ9
        c_out = din[7];
      end
      `CBS_OP_RT_RIGHT:
      begin
        dout  = {cin, din[7:1]}; // RQ10
        c_out = din[0];
      end
      `CBS_OP_SH_ARITH:
      begin
        dout  = {din[7], din[7:1]}; // RQ11 RQ13
        c_out = din[0]; // RQ13
      end
      `CBS_OP_SWAP:
      begin
        dout      = {din[3:0], din[7:4]}; // RQ12
        flags_upd = 1'b0; // RQ12
      end
      default:
      begin
        flags_upd = 1'b0;
      end
    endcase
  end

  // Overflow is negative xor carry after the shift
  assign z_out = (dout == 8'h00);
  assign n_out = dout[7];
  assign v_out = dout[7] ^ c_out;

endmodule // cbs_shift_unit

/* cbs_branch_unit.v */
// Branch condition and target computation for flag-conditioned relative branches
`timescale 1ns/100ps
`include "cbs_exec_regs.vh"

module cbs_branch_unit
#(
  parameter PC_W = 16,
  parameter K_W  = 7
)
(
  input  wire [3:0]      op,
  input  wire [PC_W-1:0] pc,
  input  wire [K_W-1:0]  k,
  input  wire [7:0]      sreg,
  output reg             taken,
  output wire            is_branch,
  output wire [PC_W-1:0] next_pc
);

  wire [PC_W-1:0] k_ext;
  wire [PC_W-1:0] pc_inc;

  // ----------------------------------------------------------------
  // Condition
  // ----------------------------------------------------------------
  always @*
  begin
    case (op)
      `CBS_OP_BR_OVF_CLR: taken = ~sreg[`CBS_F_V]; // RQ1
      `CBS_OP_BR_INT_EN:  taken = sreg[`CBS_F_I];  // RQ2
      `CBS_OP_BR_INT_DIS: taken = ~sreg[`CBS_F_I]; // RQ3
      default:            taken = 1'b0;
    endcase
  end

  assign is_branch = (op == `CBS_OP_BR_OVF_CLR) | (op == `CBS_OP_BR_INT_EN) |
                     (op == `CBS_OP_BR_INT_DIS);

  // ----------------------------------------------------------------
  // Target: signed word offset added to the incremented counter
  // ----------------------------------------------------------------
  assign k_ext   = {{(PC_W-K_W){k[K_W-1]}}, k}; // RQ14
  assign pc_inc  = pc + {{(PC_W-1){1'b0}}, 1'b1};
  assign next_pc = taken ? pc_inc + k_ext : pc_inc; // RQ1 RQ2 RQ3 RQ14

endmodule // cbs_branch_unit

/* cbs_exec_properties.sv */
// Concurrent checks on the ports of the execution block
`timescale 1ns/100ps

module cbs_exec_props
(
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        exec_busy
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Start write to the control word taken while idle
  wire start = psel && penable && pready && pwrite && paddr == 8'h00
               && pwdata[4] && !exec_busy;
  wire bad_a = paddr > 8'h18 || paddr[1:0] != 2'h0;

  chk_shift_span: assert property (start && pwdata[3:0] >= 4'h5 && pwdata[3:0] <= 4'hA
    |=> exec_busy ##1 !exec_busy) else $error("shift busy span wrong");
  chk_io_span: assert property (start && (pwdata[3:0] == 4'h3 || pwdata[3:0] == 4'h4)
    |=> exec_busy [*2] ##1 !exec_busy) else $error("io bit busy span wrong");
  chk_branch_span: assert property (start && pwdata[3:0] <= 4'h2
    |=> exec_busy ##[1:2] !exec_busy) else $error("branch busy span wrong");
  chk_busy_cause: assert property ($rose(exec_busy) |-> $past(start))
    else $error("busy without start");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_ready_answer: assert property (psel && !penable |=> pready)
    else $error("no answer in first access cycle");
  chk_err_map: assert property (pready |-> pslverr == bad_a)
    else $error("error response does not match address");
  chk_rdata_idle: assert property (!(psel && !penable) |=> $stable(prdata))
    else $error("read data changed outside answer");
  chk_wdata_zero: assert property (pready && pwrite |-> prdata == 32'h0000_0000)
    else $error("read data on write answer");
  chk_err_data: assert property (pslverr |-> prdata == 32'h0000_0000)
    else $error("read data on error");
endmodule // cbs_exec_props

bind cbs_exec_top cbs_exec_props u_props
(
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .exec_busy(exec_busy)
);

/* cbs_exec_top_tb.sv */
// Self-checking testbench for the execution block
`timescale 1ns/100ps
`include "cbs_exec_regs.vh"

module cbs_exec_top_tb;
  reg         pclk, presetn, psel, penable, pwrite;
  reg  [7:0]  paddr;
  reg  [31:0] pwdata;
  wire [31:0] prdata;
  wire        pready, pslverr, exec_busy;
  integer     failures, check_count, i;
  reg  [31:0] rd;
  reg         err;

  cbs_exec_top dut
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .exec_busy(exec_busy)
  );

  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // Reporting
  // ----------------------------------------------------------------
  task results;
    begin
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask

  task expire;
    begin
      failures = failures + 1;
      $display("MISMATCH t=%0t wait limit used up", $time);
      results;
    end
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp)
      begin
        failures = failures + 1;
        $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  // ----------------------------------------------------------------
  // Bus master: request held until pready, next setup follows at once
  // ----------------------------------------------------------------
  task xfer(input w, input [7:0] a, input [31:0] d);
    integer n;
    begin
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 16)
      begin
        n = n + 1;
        @(posedge pclk);
      end
      if (pready !== 1'b1) expire;
      rd  = prdata;
      err = pslverr;
    end
  endtask

  // ----------------------------------------------------------------
  // One operation with random operands against the bench model
  // ----------------------------------------------------------------
  task run(input [3:0] op);
    reg [7:0]  d, s, r, ns;
    reg [15:0] pc, npc;
    reg [6:0]  k;
    reg [2:0]  b;
    reg [4:0]  idx;
    reg        io, tk, c;
    integer    n;
    begin
      d = $urandom;
      s = $urandom;
      pc = $urandom;
      k = $urandom;
      b = $urandom;
      idx = $urandom;
      io = (op == 4'h3 || op == 4'h4);
      xfer(1'b1, `CBS_OFS_SEL, {26'h0, io, idx});
      xfer(1'b1, `CBS_OFS_DATA, {24'h0, d});
      xfer(1'b1, `CBS_OFS_SREG, {24'h0, s});
      xfer(1'b1, `CBS_OFS_PC, {16'h0, pc});
      xfer(1'b1, `CBS_OFS_OPERAND, {9'h0, k, 5'h0, b, 3'h0, idx});
      xfer(1'b1, `CBS_OFS_CTRL, {27'h0, 1'b1, op});
      c = s[0];
      r = d;
      ns = s;
      tk = 1'b0;
      npc = pc + 16'h0001;
      case (op)
        4'h0: tk = !s[3];
        4'h1: tk = s[7];
        4'h2: tk = !s[7];
        4'h3: r = d | (8'h01 << b);
        4'h4: r = d & ~(8'h01 << b);
        4'h5: {c, r} = {d, 1'b0};
        4'h6: {r, c} = {1'b0, d};
        4'h7: {c, r} = {d, s[0]};
        4'h8: {r, c} = {s[0], d};
        4'h9: {r, c} = {d[7], d};
        4'hA: r = {d[3:0], d[7:4]};
        default: npc = pc;
      endcase
      if (tk) npc = npc + {{9{k[6]}}, k};
      if (op >= 4'h5 && op <= 4'h9) ns[3:0] = {r[7] ^ c, r[7], r == 8'h00, c};
      n = 0;
      xfer(1'b0, `CBS_OFS_STATUS, 32'h0000_0000);
      while (rd[0] !== 1'b0 && n < 16)
      begin
        n = n + 1;
        xfer(1'b0, `CBS_OFS_STATUS, 32'h0000_0000);
      end
      if (rd[0] !== 1'b0) expire;
      chk(32'(rd[5:4]), (tk || io) ? 32'h0000_0002 : 32'h0000_0001);
      chk(32'(rd[2]), 32'(op > 4'hA));
      if (op <= 4'h2) chk(32'(rd[1]), 32'(tk));
      xfer(1'b0, `CBS_OFS_DATA, 32'h0000_0000);
      chk(rd, {24'h0, r});
      xfer(1'b0, `CBS_OFS_SREG, 32'h0000_0000);
      chk(rd, {24'h0, ns});
      xfer(1'b0, `CBS_OFS_PC, 32'h0000_0000);
      chk(rd, {16'h0, npc});
      $display("test op %0d done", op);
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    failures = 0;
    check_count = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    void'($urandom(32'h0a9efa26));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    xfer(1'b0, `CBS_OFS_SREG, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    xfer(1'b0, `CBS_OFS_PC, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    xfer(1'b0, 8'h1C, 32'h0000_0000);
    chk(32'(err), 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    $display("test reset and map done");
    for (i = 0; i < 60; i = i + 1)
      run(i % 12);
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (4) @(posedge pclk);
    results;
  end
endmodule // cbs_exec_top_tb
